// [rtl/pwt_defines.svh]
// Constants of the periodic wakeup timer: offsets, fields, reset values, timing.
`ifndef PWT_DEFINES_SVH
`define PWT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define PWT_OFS_CTRL 4'h0
`define PWT_OFS_IRQ_STATUS 4'h4
`define PWT_OFS_IRQ_MASK 4'h8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define PWT_BIT_FLAG 7
`define PWT_BIT_CLEAR 6
`define PWT_BIT_CLKSEL 5
`define PWT_BIT_IRQEN 4
`define PWT_PER_HI 2
`define PWT_PER_LO 0
`define PWT_BIT_EVT 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PWT_RST_CLKSEL 1'h0
`define PWT_RST_IRQEN 1'h0
`define PWT_RST_PERIOD 3'h0
`define PWT_RST_MASK 1'h0
`define PWT_PER_OFF 3'h0

// ----------------------------------------------------------------------------
// Timing: internal tick 1.15 ms, base period is 8 ticks (9.2 ms)
// ----------------------------------------------------------------------------
`define PWT_CLK_HZ 10000000
`define PWT_TICK_NS 1150000
`define PWT_TICK_CYC ((`PWT_TICK_NS * (`PWT_CLK_HZ / 1000000)) / 1000)
`define PWT_INT_BASE_TICKS 8
`define PWT_CNT_W 16

// ----------------------------------------------------------------------------
// External source: edges per period for codes one to seven, zero when stopped
// ----------------------------------------------------------------------------
`define PWT_EXT_EDGES_OFF 16'h0000
`define PWT_EXT_EDGES_1 16'h0100
`define PWT_EXT_EDGES_2 16'h0400
`define PWT_EXT_EDGES_3 16'h0800
`define PWT_EXT_EDGES_4 16'h1000
`define PWT_EXT_EDGES_5 16'h2000
`define PWT_EXT_EDGES_6 16'h4000
`define PWT_EXT_EDGES_7 16'h8000

`endif

// [rtl/pwt_pkg.sv]
// Types shared by the periodic wakeup timer.
package pwt_pkg;
    // Control register view of the timer
    typedef struct packed {
        logic       clock_select;
        logic       irq_enable;
        logic [2:0] period_select;
    } pwt_ctrl_s;
endpackage

// [rtl/pwt_periodic_wakeup_timer.sv]
// Periodic wakeup timer with a classic Wishbone register slave.
// Contract
// - Bit 7 reads the timeout flag, set on expiry, read-only.
// - Writing one to bit 6 clears the timeout flag.
// - Writing zero to bit 6 changes nothing; bit 6 reads zero.
// - Bit 5 picks tick source: zero internal oscillator, one external clock.
// - Bit 4 enables the timer interrupt request.
// - Bits 2 to 0 select the period, meaning depends on source.
// - Internal codes give 9.2 ms doubling up to 1177.6 ms; zero runs.
// - External source with code zero stops the timer entirely.
// - External codes one to seven multiply external period by 256..32768.
// - Internal tick runs independently of other clocks in the device; here it is divided down from clk_i.
// - Unimplemented control bits ignore writes and read zero.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "pwt_defines.svh"

module pwt_periodic_wakeup_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // External tick source (pin, asynchronous)
    input wire logic ext_clk_i,
    // Interrupt request and flag
    output logic irq_o,
    output logic timeout_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    pwt_pkg::pwt_ctrl_s ctrl_q;
    logic wakeup_timeout_flag_q;
    logic evt_status_q;
    logic evt_mask_q;
    logic [15:0] tick_div_q;
    logic int_tick;
    logic [2:0] ext_sync_q;
    logic ext_tick;
    logic [`PWT_CNT_W-1:0] per_cnt_q;
    logic [`PWT_CNT_W-1:0] per_limit;
    logic tick;
    logic expire;
    logic req;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic [31:0] rd_data;
    logic src_change_q;
    logic wr_any;
    logic rd_en;
    logic [`PWT_CNT_W-1:0] per_cnt_d;
    logic [`PWT_CNT_W-1:0] ext_limit;
    logic [`PWT_CNT_W-1:0] int_limit;
    logic ext_off;
    logic restart;
    logic flag_d;
    logic status_d;
    logic irq_cause;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // One-cycle acknowledge; request taken when ack is low
    assign req = cyc_i && stb_i && !ack_o;

    // Writes need the low byte lane, where every field lives
    assign wr_any = req && we_i && sel_i[0];
    assign rd_en = req && !we_i;

    // One write strobe per register
    assign wr_ctrl = wr_any && (adr_i == `PWT_OFS_CTRL);
    assign wr_stat = wr_any && (adr_i == `PWT_OFS_IRQ_STATUS);
    assign wr_mask = wr_any && (adr_i == `PWT_OFS_IRQ_MASK);

    // Ack generation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (adr_i)
            `PWT_OFS_CTRL: begin
                rd_data[`PWT_BIT_FLAG] = wakeup_timeout_flag_q;
                rd_data[`PWT_BIT_CLEAR] = 1'b0;
                rd_data[`PWT_BIT_CLKSEL] = ctrl_q.clock_select;
                rd_data[`PWT_BIT_IRQEN] = ctrl_q.irq_enable;
                rd_data[`PWT_PER_HI:`PWT_PER_LO] = ctrl_q.period_select;
            end
            `PWT_OFS_IRQ_STATUS: begin
                rd_data[`PWT_BIT_EVT] = evt_status_q;
            end
            `PWT_OFS_IRQ_MASK: begin
                rd_data[`PWT_BIT_EVT] = evt_mask_q;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_en) begin
            dat_o <= rd_data;
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    // Writable fields; bit 3 and other positions are not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q.clock_select <= `PWT_RST_CLKSEL;
            ctrl_q.irq_enable <= `PWT_RST_IRQEN;
            ctrl_q.period_select <= `PWT_RST_PERIOD;
        end else if (wr_ctrl) begin
            ctrl_q.clock_select <= dat_i[`PWT_BIT_CLKSEL];
            ctrl_q.irq_enable <= dat_i[`PWT_BIT_IRQEN];
            ctrl_q.period_select <= dat_i[`PWT_PER_HI:`PWT_PER_LO];
        end
    end

    // Restart the period count the cycle after any control register write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_change_q <= 1'b0;
        end else begin
            src_change_q <= wr_ctrl;
        end
    end

    // ------------------------------------------------------------------------
    // Tick sources
    // ------------------------------------------------------------------------
    // Internal oscillator model: free-running divider, never gated by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_div_q <= 16'h0000;
        end else if (int_tick) begin
            tick_div_q <= 16'h0000;
        end else begin
            tick_div_q <= tick_div_q + 16'h0001;
        end
    end
    assign int_tick = (tick_div_q == 16'(`PWT_TICK_CYC - 1));

    // External clock: two-stage synchroniser, edge taken from stages two and three
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_clk_i};
        end
    end
    assign ext_tick = ext_sync_q[1] && !ext_sync_q[2];

    // Source select
    assign tick = ctrl_q.clock_select ? ext_tick : int_tick;

    // ------------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------------
    // External source: edges per period for each code, zero means stopped
    always_comb begin
        unique case (ctrl_q.period_select)
            3'h1: ext_limit = `PWT_EXT_EDGES_1;
            3'h2: ext_limit = `PWT_EXT_EDGES_2;
            3'h3: ext_limit = `PWT_EXT_EDGES_3;
            3'h4: ext_limit = `PWT_EXT_EDGES_4;
            3'h5: ext_limit = `PWT_EXT_EDGES_5;
            3'h6: ext_limit = `PWT_EXT_EDGES_6;
            3'h7: ext_limit = `PWT_EXT_EDGES_7;
            default: ext_limit = `PWT_EXT_EDGES_OFF;
        endcase
    end

    // Internal source: eight ticks (9.2 ms) doubled per code, up to 1177.6 ms
    assign int_limit = 16'(`PWT_INT_BASE_TICKS) << ctrl_q.period_select;

    // Ticks per period for the selected source
    assign per_limit = ctrl_q.clock_select ? ext_limit : int_limit;

    // External source with code zero holds the timer still
    assign ext_off = ctrl_q.clock_select && (ctrl_q.period_select == `PWT_PER_OFF);

    // Control writes and a stopped external source hold the count at zero
    assign restart = src_change_q || ext_off;

    // Last tick of a period; a zero limit never expires
    assign expire = tick && (per_limit != `PWT_EXT_EDGES_OFF)
                    && (per_cnt_q == per_limit - 16'h0001);

    // Next count: cleared on restart and on expiry, so timing repeats
    always_comb begin
        per_cnt_d = per_cnt_q;
        if (restart || expire) begin
            per_cnt_d = 16'h0000;
        end else if (tick) begin
            per_cnt_d = per_cnt_q + 16'h0001;
        end
    end

    // Period counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_cnt_q <= 16'h0000;
        end else begin
            per_cnt_q <= per_cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------------------
    // Timeout flag next value; expiry wins over a clear in the same cycle
    always_comb begin
        flag_d = wakeup_timeout_flag_q;
        if (expire) begin
            flag_d = 1'b1;
        end else if (wr_ctrl && dat_i[`PWT_BIT_CLEAR]) begin
            flag_d = 1'b0;
        end
    end

    // Timeout flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wakeup_timeout_flag_q <= 1'b0;
        end else begin
            wakeup_timeout_flag_q <= flag_d;
        end
    end

    // Sticky event status next value, write one to clear, set wins
    always_comb begin
        status_d = evt_status_q;
        if (expire) begin
            status_d = 1'b1;
        end else if (wr_stat && dat_i[`PWT_BIT_EVT]) begin
            status_d = 1'b0;
        end
    end

    // Event status register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status_q <= 1'b0;
        end else begin
            evt_status_q <= status_d;
        end
    end

    // Event mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_mask_q <= `PWT_RST_MASK;
        end else if (wr_mask) begin
            evt_mask_q <= dat_i[`PWT_BIT_EVT];
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Interrupt cause: enabled flag or unmasked event status
    assign irq_cause = (wakeup_timeout_flag_q && ctrl_q.irq_enable)
                       || (evt_status_q && evt_mask_q);

    // Interrupt request output, registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_cause;
        end
    end

    // Timeout flag copy on a pin, registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_o <= 1'b0;
        end else begin
            timeout_o <= wakeup_timeout_flag_q;
        end
    end

endmodule // pwt_periodic_wakeup_timer

// [tb/pwt_properties.sv]
// Concurrent checks on the ports of the periodic wakeup timer.
`timescale 1ns/10ps
module pwt_properties (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Timer pins
    input wire logic ext_clk_i,
    input wire logic irq_o,
    input wire logic timeout_o
);
    // Single clock domain, checks idle during reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_follows_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    ack_one_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    read_idle_zero_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
    ack_needs_req_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
    clear_bit_zero_a: assert property (ack_o && !we_i |-> !dat_o[6])
        else $error("clear bit read one");
    unused_bits_zero_a: assert property (ack_o && !we_i && adr_i == 4'h0
        |-> dat_o[31:8] == 24'h0 && !dat_o[3]) else $error("unused bit read one");
    flag_clear_a: assert property (ack_o && we_i && adr_i == 4'h0 && sel_i[0] && dat_i[6]
        |-> ##1 !timeout_o) else $error("flag not cleared");
    flag_falls_a: assert property ($fell(timeout_o)
        |-> $past(ack_o && we_i && adr_i == 4'h0 && sel_i[0] && dat_i[6]))
        else $error("flag fell without clear");
    // Main scenarios reached
    cover property (ack_o && we_i);
    cover property ($rose(timeout_o));
    cover property ($rose(irq_o));
    cover property ($fell(timeout_o));
endmodule // pwt_properties

bind pwt_periodic_wakeup_timer pwt_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(ext_clk_i), .irq_o(irq_o), .timeout_o(timeout_o));

// [tb/pwt_periodic_wakeup_timer_tb.sv]
// Self-checking testbench of the periodic wakeup timer.
`timescale 1ns/10ps
module pwt_periodic_wakeup_timer_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ext_clk_i = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, irq_o, timeout_o;
    logic [7:0] d;
    int failures = 0, n_tests = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    pwt_periodic_wakeup_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .ext_clk_i(ext_clk_i), .irq_o(irq_o), .timeout_o(timeout_o));

    // ------------------------------------------------------------------------
    // Bus cycle, comparison and tick tasks
    // ------------------------------------------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v,
                      input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, v};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Rising edges on the external tick pin, four clock cycles apart
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge clk_i);
            ext_clk_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_clk_i <= 1'b0;
            @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i); // Let synchroniser and flag settle
    endtask

    function automatic int ext_len(input int c);
        return (c == 1) ? 256 : (256 << c);
    endfunction

    task automatic results;
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'h1df82aac));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h0, 8'h00, 4'hF, rd);
        chk("ctrl reset", 32'h0, rd);
        wb(1'b0, 4'h8, 8'h00, 4'hF, rd);
        chk("mask reset", 32'h0, rd);
        repeat (8) begin
            d = 8'($urandom);
            wb(1'b1, 4'h0, d, 4'hF, rd);
            wb(1'b0, 4'h0, 8'h00, 4'hF, rd);
            chk("ctrl rw", {24'h0, d & 8'h37}, rd);
        end
        wb(1'b1, 4'h0, ~d, 4'hE, rd);
        wb(1'b0, 4'h0, 8'h00, 4'hF, rd);
        chk("ctrl lane off", {24'h0, d & 8'h37}, rd);
        wb(1'b1, 4'hC, 8'hFF, 4'hF, rd);
        wb(1'b0, 4'hC, 8'h00, 4'hF, rd);
        chk("unmapped", 32'h0, rd);
        for (int c = 1; c < 5; c++) begin
            wb(1'b1, 4'h0, 8'(8'h70 | c), 4'hF, rd);
            edges(ext_len(c) - 1);
            chk("flag early", 32'h0, {31'h0, timeout_o});
            edges(1);
            chk("flag", 32'h1, {31'h0, timeout_o});
            chk("irq on", 32'h1, {31'h0, irq_o});
            wb(1'b1, 4'h0, 8'(8'h20 | c), 4'hF, rd);
            wb(1'b0, 4'h0, 8'h00, 4'hF, rd);
            chk("flag kept", 32'hA0 | c, rd);
            chk("irq gated", 32'h0, {31'h0, irq_o});
        end
        wb(1'b1, 4'h0, 8'h60, 4'hF, rd);
        wb(1'b0, 4'h4, 8'h00, 4'hF, rd);
        chk("status set", 32'h1, rd);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wb(1'b1, 4'h8, 8'h01, 4'hF, rd);
        wb(1'b0, 4'h8, 8'h00, 4'hF, rd);
        chk("mask rw", 32'h1, rd);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        wb(1'b1, 4'h4, 8'h01, 4'hF, rd);
        wb(1'b0, 4'h4, 8'h00, 4'hF, rd);
        chk("status clear", 32'h0, rd);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        edges(300);
        chk("ext code zero", 32'h0, {31'h0, timeout_o});
        results;
    end

    // Watchdog against a hung handshake or timer
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        results;
    end
endmodule // pwt_periodic_wakeup_timer_tb
